// file: hw/pcc_regs.vh
// Register offsets, field layout, reset values and timing counts
`ifndef PCC_REGS_VH
`define PCC_REGS_VH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define PCC_OFS_PWRMODE   8'h00
`define PCC_OFS_PERIPHON  8'h04
`define PCC_OFS_CLKDIV    8'h08
`define PCC_OFS_VECMAP    8'h0C
`define PCC_OFS_EXTFLAG   8'h10
`define PCC_OFS_EXTMODE   8'h14
`define PCC_OFS_EXTPOL    8'h18
`define PCC_OFS_EXTWAKE   8'h1C
`define PCC_OFS_EXTROUTE  8'h20
`define PCC_OFS_INTSTAT   8'h24
`define PCC_OFS_INTMASK   8'h28
`define PCC_OFS_STATE     8'h2C

// ---------------------------------------------------------------
// Widths and field positions
// ---------------------------------------------------------------
`define PCC_NUM_EXT       9
`define PCC_NUM_LINE      4
`define PCC_NUM_PERIPH    12
`define PCC_NUM_EVT       3
`define PCC_PWR_IDLE_BIT  0
`define PCC_PWR_DOWN_BIT  1
`define PCC_EVT_IDLE_WAKE 0
`define PCC_EVT_PD_WAKE   1
`define PCC_EVT_DIV_DONE  2

// ---------------------------------------------------------------
// Divider codes and reset values
// ---------------------------------------------------------------
`define PCC_DIV_QUARTER   2'h0
`define PCC_DIV_FULL      2'h1
`define PCC_DIV_HALF      2'h2
`define PCC_RST_DIV       2'h0
`define PCC_RST_PERIPHON  12'hFFF
`define PCC_RST_VECMAP    1'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define PCC_CLK_PERIOD_NS 4
`define PCC_WAKE_TIME_NS  1000
`define PCC_WAKE_CYC      ((`PCC_WAKE_TIME_NS + `PCC_CLK_PERIOD_NS - 1) / `PCC_CLK_PERIOD_NS)

`endif

// file: hw/pcc_ext_in.v
// One external interrupt input: synchroniser, polarity, edge or level detect
`timescale 1ns/100ps

module pcc_ext_in
(
  sys_clk,
  nrst,
  pin,
  edge_mode,
  act_high,
  clr,
  flag
);
  input  wire sys_clk;
  input  wire nrst;
  input  wire pin;
  input  wire edge_mode;
  input  wire act_high;
  input  wire clr;
  output wire flag;

  reg  [2:0] sync_ff;
  reg        stable_ff;
  reg        sticky_ff;
  wire       agree;
  wire       active;
  wire       rise;

  // ---------------------------------------------------------------
  // Three-stage synchroniser, change taken when stages two and three agree
  // ---------------------------------------------------------------
  assign agree  = (sync_ff[1] == sync_ff[2]);
  assign active = act_high ? stable_ff : ~stable_ff;
  assign rise   = agree & ((act_high ? sync_ff[2] : ~sync_ff[2]) & ~active);

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      sync_ff   <= 3'h0;
      stable_ff <= 1'h0;
      sticky_ff <= 1'h0;
    end
    else
    begin
      sync_ff <= {sync_ff[1:0], pin};
      if (agree)
        stable_ff <= sync_ff[2];
      // Set wins over a simultaneous clear
      if (rise)
        sticky_ff <= 1'h1;
      else if (clr)
        sticky_ff <= 1'h0;
    end
  end

  // Level mode follows the pin, edge mode holds until cleared
  assign flag = edge_mode ? sticky_ff : active;

endmodule // pcc_ext_in

// file: hw/pcc_top.v
// Power and clock control: power modes, divider, gating, external interrupts
`timescale 1ns/100ps
`include "pcc_regs.vh"

module pcc_top
(
  sys_clk,
  nrst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  ext_pin,
  periph_irq,
  osc_ready,
  ext_irq_line,
  cpu_clk_en,
  periph_clk_en,
  pclk_en,
  osc_enable,
  mult_keep,
  pin_hold,
  vec_in_ram,
  irq
);
  input  wire                        sys_clk;
  input  wire                        nrst;
  input  wire [7:0]                  reg_addr;
  input  wire [31:0]                 reg_wdata;
  input  wire                        reg_wr;
  input  wire                        reg_rd;
  output reg  [31:0]                 reg_rdata;
  input  wire [`PCC_NUM_EXT-1:0]     ext_pin;
  input  wire                        periph_irq;
  input  wire                        osc_ready;
  output wire [`PCC_NUM_LINE-1:0]    ext_irq_line;
  output wire                        cpu_clk_en;
  output wire [`PCC_NUM_PERIPH-1:0]  periph_clk_en;
  output wire                        pclk_en;
  output wire                        osc_enable;
  output wire                        mult_keep;
  output wire                        pin_hold;
  output wire                        vec_in_ram;
  output wire                        irq;

  localparam ST_RUN  = 2'h0;
  localparam ST_IDLE = 2'h1;
  localparam ST_DOWN = 2'h2;
  localparam ST_WAKE = 2'h3;
  localparam integer WAKE_INT = `PCC_WAKE_CYC;
  localparam [11:0] WAKE_CYC = WAKE_INT[11:0];

  reg  [1:0]                   state_ff;
  reg  [1:0]                   nxt_state;
  reg  [`PCC_NUM_PERIPH-1:0]   periph_on_ff;
  reg  [1:0]                   div_sel_ff;
  reg  [1:0]                   div_act_ff;
  reg  [1:0]                   div_cnt_ff;
  reg                          vec_ram_ff;
  reg  [`PCC_NUM_EXT-1:0]      ext_mode_ff;
  reg  [`PCC_NUM_EXT-1:0]      ext_pol_ff;
  reg  [`PCC_NUM_EXT-1:0]      ext_wake_ff;
  reg  [2*`PCC_NUM_EXT-1:0]    ext_route_ff;
  reg  [`PCC_NUM_EVT-1:0]      int_stat_ff;
  reg  [`PCC_NUM_EVT-1:0]      int_mask_ff;
  reg  [11:0]                  wake_cnt_ff;
  reg  [2:0]                   osc_sync_ff;
  reg                          osc_ok_ff;
  reg  [3:0]                   line_acc;
  reg  [31:0]                  nxt_rdata;
  reg  [`PCC_NUM_EVT-1:0]      evt;
  wire [`PCC_NUM_EXT-1:0]      ext_flag;
  wire [`PCC_NUM_EXT-1:0]      ext_clr;
  wire                         wr_pwr;
  wire                         any_line;
  wire                         pd_wake;
  wire                         div_edge;
  wire [1:0]                   div_last;
  integer                      i;

  // ---------------------------------------------------------------
  // External interrupt inputs
  // ---------------------------------------------------------------
  assign ext_clr = (reg_wr && reg_addr == `PCC_OFS_EXTFLAG) ?
                   reg_wdata[`PCC_NUM_EXT-1:0] : {`PCC_NUM_EXT{1'b0}};

  genvar g;
  generate
    for (g = 0; g < `PCC_NUM_EXT; g = g + 1)
    begin : gen_ext
      pcc_ext_in u_ext
      (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .pin       (ext_pin[g]),
        .edge_mode (ext_mode_ff[g]),
        .act_high  (ext_pol_ff[g]),
        .clr       (ext_clr[g]),
        .flag      (ext_flag[g])
      );
    end
  endgenerate

  // Each input joins the line picked by its two route bits
  always @*
  begin
    line_acc = 4'h0;
    for (i = 0; i < `PCC_NUM_EXT; i = i + 1)
      line_acc[ext_route_ff[2*i +: 2]] = line_acc[ext_route_ff[2*i +: 2]]
                                         | ext_flag[i];
  end

  assign ext_irq_line = line_acc;
  assign any_line     = |line_acc;
  assign pd_wake      = |(ext_flag & ext_wake_ff);

  // ---------------------------------------------------------------
  // Oscillator ready synchroniser
  // ---------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      osc_sync_ff <= 3'h0;
      osc_ok_ff   <= 1'h0;
    end
    else
    begin
      osc_sync_ff <= {osc_sync_ff[1:0], osc_ready};
      if (osc_sync_ff[1] == osc_sync_ff[2])
        osc_ok_ff <= osc_sync_ff[2];
    end
  end

  // ---------------------------------------------------------------
  // Power mode state machine
  // ---------------------------------------------------------------
  assign wr_pwr = reg_wr && (reg_addr == `PCC_OFS_PWRMODE);

  always @*
  begin
    nxt_state = state_ff;
    evt       = {`PCC_NUM_EVT{1'b0}};
    case (state_ff)
      ST_RUN:
      begin
        // Power-down wins when both mode bits are written
        if (wr_pwr && reg_wdata[`PCC_PWR_DOWN_BIT])
          nxt_state = ST_DOWN;
        else if (wr_pwr && reg_wdata[`PCC_PWR_IDLE_BIT])
          nxt_state = ST_IDLE;
      end
      ST_IDLE:
      begin
        if (any_line || periph_irq)
        begin
          nxt_state = ST_RUN;
          evt[`PCC_EVT_IDLE_WAKE] = 1'b1;
        end
      end
      ST_DOWN:
      begin
        if (pd_wake)
          nxt_state = ST_WAKE;
      end
      ST_WAKE:
      begin
        if (osc_ok_ff && wake_cnt_ff == WAKE_CYC - 12'h001)
        begin
          nxt_state = ST_RUN;
          evt[`PCC_EVT_PD_WAKE] = 1'b1;
        end
      end
      default:
        nxt_state = ST_RUN;
    endcase
    if (div_edge && div_act_ff != div_sel_ff)
      evt[`PCC_EVT_DIV_DONE] = 1'b1;
  end

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_ff    <= ST_RUN;
      wake_cnt_ff <= 12'h000;
    end
    else
    begin
      state_ff <= nxt_state;
      // Timer only counts once the oscillator is seen stable
      if (state_ff == ST_WAKE && osc_ok_ff)
        wake_cnt_ff <= wake_cnt_ff + 12'h001;
      else
        wake_cnt_ff <= 12'h000;
    end
  end

  // CPU halted in idle, down and wake; registers are not reset here
  assign cpu_clk_en = (state_ff == ST_RUN);
  assign osc_enable = (state_ff != ST_DOWN);
  assign pin_hold   = (state_ff == ST_DOWN) ||
                      (state_ff == ST_WAKE);
  assign mult_keep  = (state_ff == ST_RUN) ||
                      (state_ff == ST_IDLE);

  // ---------------------------------------------------------------
  // Peripheral clock divider
  // ---------------------------------------------------------------
  assign div_last = (div_act_ff == `PCC_DIV_FULL) ? 2'h0 :
                    (div_act_ff == `PCC_DIV_HALF) ? 2'h1 : 2'h3;
  assign div_edge = (div_cnt_ff == div_last);

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      div_act_ff <= `PCC_RST_DIV;
      div_cnt_ff <= 2'h0;
    end
    else if (state_ff == ST_RUN || state_ff == ST_IDLE)
    begin
      if (div_edge)
      begin
        div_cnt_ff <= 2'h0;
        // New ratio taken only at the end of a whole period
        div_act_ff <= div_sel_ff;
      end
      else
        div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  assign pclk_en = div_edge &&
                   (state_ff == ST_RUN || state_ff == ST_IDLE);
  assign periph_clk_en = (state_ff == ST_RUN || state_ff == ST_IDLE) ?
                         periph_on_ff : {`PCC_NUM_PERIPH{1'b0}};
  assign vec_in_ram = vec_ram_ff;

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      periph_on_ff <= `PCC_RST_PERIPHON;
      div_sel_ff   <= `PCC_RST_DIV;
      vec_ram_ff   <= `PCC_RST_VECMAP;
      ext_mode_ff  <= {`PCC_NUM_EXT{1'b0}};
      ext_pol_ff   <= {`PCC_NUM_EXT{1'b1}};
      ext_wake_ff  <= {`PCC_NUM_EXT{1'b0}};
      ext_route_ff <= {2*`PCC_NUM_EXT{1'b0}};
      int_mask_ff  <= {`PCC_NUM_EVT{1'b0}};
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `PCC_OFS_PERIPHON: periph_on_ff <= reg_wdata[`PCC_NUM_PERIPH-1:0];
        `PCC_OFS_CLKDIV:
        begin
          // Reserved code 3 falls back to quarter rate
          if (reg_wdata[1:0] == 2'h3)
            div_sel_ff <= `PCC_DIV_QUARTER;
          else
            div_sel_ff <= reg_wdata[1:0];
        end
        `PCC_OFS_VECMAP:   vec_ram_ff   <= reg_wdata[0];
        `PCC_OFS_EXTMODE:  ext_mode_ff  <= reg_wdata[`PCC_NUM_EXT-1:0];
        `PCC_OFS_EXTPOL:   ext_pol_ff   <= reg_wdata[`PCC_NUM_EXT-1:0];
        `PCC_OFS_EXTWAKE:  ext_wake_ff  <= reg_wdata[`PCC_NUM_EXT-1:0];
        `PCC_OFS_EXTROUTE: ext_route_ff <= reg_wdata[2*`PCC_NUM_EXT-1:0];
        `PCC_OFS_INTMASK:  int_mask_ff  <= reg_wdata[`PCC_NUM_EVT-1:0];
        default:           int_mask_ff  <= int_mask_ff;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status, write one to clear, set wins
  // ---------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!nrst)
      int_stat_ff <= {`PCC_NUM_EVT{1'b0}};
    else if (reg_wr && reg_addr == `PCC_OFS_INTSTAT)
      int_stat_ff <= (int_stat_ff & ~reg_wdata[`PCC_NUM_EVT-1:0]) | evt;
    else
      int_stat_ff <= int_stat_ff | evt;
  end

  assign irq = |(int_stat_ff & int_mask_ff);

  // ---------------------------------------------------------------
  // Register reads, data one cycle after the strobe
  // ---------------------------------------------------------------
  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    case (reg_addr)
      `PCC_OFS_PWRMODE:  nxt_rdata[1:0] = {state_ff == ST_DOWN, state_ff == ST_IDLE};
      `PCC_OFS_PERIPHON: nxt_rdata[`PCC_NUM_PERIPH-1:0] = periph_on_ff;
      `PCC_OFS_CLKDIV:   nxt_rdata[1:0] = div_sel_ff;
      `PCC_OFS_VECMAP:   nxt_rdata[0] = vec_ram_ff;
      `PCC_OFS_EXTFLAG:  nxt_rdata[`PCC_NUM_EXT-1:0] = ext_flag;
      `PCC_OFS_EXTMODE:  nxt_rdata[`PCC_NUM_EXT-1:0] = ext_mode_ff;
      `PCC_OFS_EXTPOL:   nxt_rdata[`PCC_NUM_EXT-1:0] = ext_pol_ff;
      `PCC_OFS_EXTWAKE:  nxt_rdata[`PCC_NUM_EXT-1:0] = ext_wake_ff;
      `PCC_OFS_EXTROUTE: nxt_rdata[2*`PCC_NUM_EXT-1:0] = ext_route_ff;
      `PCC_OFS_INTSTAT:  nxt_rdata[`PCC_NUM_EVT-1:0] = int_stat_ff;
      `PCC_OFS_INTMASK:  nxt_rdata[`PCC_NUM_EVT-1:0] = int_mask_ff;
      `PCC_OFS_STATE:    nxt_rdata[5:0] = {div_act_ff, osc_ok_ff, 1'b0, state_ff};
      default:           nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (!nrst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= nxt_rdata;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule // pcc_top

// file: verif/pcc_osc_model.sv
// Oscillator stand-in: stable indication after a start-up delay
`timescale 1ns/100ps

module pcc_osc_model
#(
  parameter int START_CYC = 20
)
(
  input  wire logic sys_clk,
  input  wire logic osc_enable,
  output logic      osc_ready
);
  int cnt_ff = 0;

  assign osc_ready = (cnt_ff >= START_CYC);

  always @(posedge sys_clk)
  begin
    if (!osc_enable)
      cnt_ff <= 0;
    else if (cnt_ff < START_CYC)
      cnt_ff <= cnt_ff + 1;
  end
endmodule // pcc_osc_model

// file: verif/pcc_top_assertions.sv
// Concurrent checks on the power and clock control ports
`timescale 1ns/100ps
`include "pcc_regs.vh"

module pcc_top_chk
(
  input wire logic                      sys_clk,
  input wire logic                      nrst,
  input wire logic [7:0]                reg_addr,
  input wire logic [31:0]               reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      osc_ready,
  input wire logic                      cpu_clk_en,
  input wire logic [`PCC_NUM_PERIPH-1:0] periph_clk_en,
  input wire logic                      pclk_en,
  input wire logic                      osc_enable,
  input wire logic                      mult_keep,
  input wire logic                      pin_hold,
  input wire logic                      vec_in_ram
);
  logic        wr_ff;
  logic [7:0]  ad_ff;
  logic [31:0] wd_ff;
  logic [9:0]  stab_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // ---------------------------------------------------------------
  // Last bus write and stable-oscillator run length
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    wr_ff <= reg_wr;
    ad_ff <= reg_addr;
    wd_ff <= reg_wdata;
    if (!nrst || !pin_hold || !osc_ready)
      stab_ff <= 10'h000;
    else if (stab_ff != 10'h3FF)
      stab_ff <= stab_ff + 10'h001;
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  property p_down_gated;
    !osc_enable |-> !cpu_clk_en && !pclk_en && periph_clk_en == '0;
  endproperty
  a_down_gated: assert property (p_down_gated)
    else $error("clock alive in power-down");

  property p_down_hold;
    !osc_enable |-> pin_hold && !mult_keep;
  endproperty
  a_down_hold: assert property (p_down_hold)
    else $error("pins not frozen in power-down");

  property p_idle_mult;
    !cpu_clk_en && !pin_hold |-> mult_keep && osc_enable;
  endproperty
  a_idle_mult: assert property (p_idle_mult)
    else $error("multiplier dropped in idle");

  property p_idle_pclk;
    (!cpu_clk_en && !pin_hold)[*4] |-> pclk_en || $past(pclk_en) || $past(pclk_en, 2)
      || $past(pclk_en, 3);
  endproperty
  a_idle_pclk: assert property (p_idle_pclk)
    else $error("peripheral clock stopped in idle");

  property p_halt_cause;
    $fell(cpu_clk_en) |-> wr_ff && ad_ff == `PCC_OFS_PWRMODE && wd_ff[1:0] != 2'h0;
  endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("cpu halted without mode write");

  property p_wake_timer;
    $rose(cpu_clk_en) && $past(pin_hold) |-> stab_ff >= 10'(`PCC_WAKE_CYC);
  endproperty
  a_wake_timer: assert property (p_wake_timer)
    else $error("wake before oscillator settled");

  property p_pclk_gap;
    pclk_en |-> ##[1:4] (pclk_en || pin_hold);
  endproperty
  a_pclk_gap: assert property (p_pclk_gap)
    else $error("peripheral clock period out of range");

  property p_vecmap;
    $changed(vec_in_ram) |-> wr_ff && ad_ff == `PCC_OFS_VECMAP && vec_in_ram == wd_ff[0];
  endproperty
  a_vecmap: assert property (p_vecmap)
    else $error("vector map changed without write");

  property p_pgate;
    !pin_hold && $past(!pin_hold) && $changed(periph_clk_en) |->
      wr_ff && ad_ff == `PCC_OFS_PERIPHON;
  endproperty
  a_pgate: assert property (p_pgate)
    else $error("peripheral enable changed without write");
endmodule // pcc_top_chk

bind pcc_top pcc_top_chk i_pcc_top_chk (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .osc_ready(osc_ready), .cpu_clk_en(cpu_clk_en),
  .periph_clk_en(periph_clk_en), .pclk_en(pclk_en), .osc_enable(osc_enable),
  .mult_keep(mult_keep), .pin_hold(pin_hold), .vec_in_ram(vec_in_ram));

// file: verif/pcc_top_tb.sv
// Self-checking bench for the power and clock control block
`timescale 1ns/100ps
`include "pcc_regs.vh"

module pcc_top_tb;
  localparam int NR = 14;
  logic                      sys_clk = 1'b0;
  logic                      nrst = 1'b0;
  logic [7:0]                reg_addr = 8'h00;
  logic [31:0]               reg_wdata = 32'h0;
  logic                      reg_wr = 1'b0;
  logic                      reg_rd = 1'b0;
  logic [`PCC_NUM_EXT-1:0]   ext_pin = 9'h000;
  logic                      periph_irq = 1'b0;
  logic [31:0]               reg_rdata, d;
  logic [`PCC_NUM_LINE-1:0]  line;
  logic [`PCC_NUM_PERIPH-1:0] pce;
  logic                      osc_ready, cpu_clk_en, pclk_en, osc_enable;
  logic                      mult_keep, pin_hold, vec_in_ram, irq;
  int                        error_cnt = 0, samples_checked = 0, i, n;
  logic [7:0]  ra [NR] = '{`PCC_OFS_PERIPHON, `PCC_OFS_CLKDIV, `PCC_OFS_EXTPOL,
    `PCC_OFS_VECMAP, `PCC_OFS_EXTMODE, `PCC_OFS_PERIPHON, `PCC_OFS_CLKDIV, `PCC_OFS_CLKDIV,
    `PCC_OFS_VECMAP, `PCC_OFS_EXTROUTE, `PCC_OFS_INTMASK, 8'h40, `PCC_OFS_EXTWAKE,
    `PCC_OFS_EXTMODE};
  logic        we [NR] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 1, 1};
  logic [31:0] rw [NR] = '{0, 0, 0, 0, 0, 32'hA5A, 32'h3, 32'h2, 32'h1, '1, '1, '1, 32'h1,
    32'h1};
  logic [31:0] rx [NR] = '{32'hFFF, 0, 32'h1FF, 0, 0, 32'hA5A, 0, 32'h2, 32'h1, 32'h3FFFF,
    32'h7, 0, 32'h1, 32'h1};

  pcc_top i_pcc_top (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_pin(ext_pin), .periph_irq(periph_irq), .osc_ready(osc_ready), .ext_irq_line(line),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(pce), .pclk_en(pclk_en),
    .osc_enable(osc_enable), .mult_keep(mult_keep), .pin_hold(pin_hold),
    .vec_in_ram(vec_in_ram), .irq(irq));
  pcc_osc_model i_pcc_osc_model (.sys_clk(sys_clk), .osc_enable(osc_enable),
    .osc_ready(osc_ready));

  always #2 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // Bus, compare and timing helpers
  // ---------------------------------------------------------------
  task automatic cyc;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tmo(input logic ok);
    if (!ok)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      tally_and_finish;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // Cycles from one peripheral clock pulse to the next
  task automatic per(output int p);
    for (i = 0; i < 9 && pclk_en !== 1'b1; i++)
      cyc;
    tmo(i < 9);
    p = 0;
    do
    begin
      cyc;
      p++;
    end
    while (pclk_en !== 1'b1 && p < 9);
  endtask

  initial
  begin
    #200000;
    tmo(1'b0);
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    cyc;
    per(n);
    chk(32'(n), 32'h4);
    for (int r = 0; r < NR; r++)
    begin
      if (we[r])
        wr(ra[r], rw[r]);
      rd(ra[r], d);
      chk(d, rx[r]);
    end
    chk({31'h0, vec_in_ram}, 32'h1);
    rd(`PCC_OFS_INTSTAT, d);
    chk(d, 32'h4);
    wr(`PCC_OFS_INTSTAT, 32'h7);
    cyc;
    chk({31'h0, irq}, 32'h0);
    per(n);
    chk(32'(n), 32'h2);
    wr(`PCC_OFS_CLKDIV, 32'h1);
    per(n);
    per(n);
    chk(32'(n), 32'h1);
    $display("test registers and divider done");
    wr(`PCC_OFS_EXTROUTE, 32'h2);
    ext_pin[0] <= 1'b1;
    for (i = 0; i < 10 && line !== 4'h4; i++)
      cyc;
    tmo(i < 10);
    @(posedge sys_clk);
    ext_pin[0] <= 1'b0;
    repeat (6) cyc;
    chk({28'h0, line}, 32'h4);
    wr(`PCC_OFS_EXTFLAG, 32'h1);
    ext_pin[1] <= 1'b1;
    cyc;
    chk({28'h0, line}, 32'h0);
    for (i = 0; i < 10 && line !== 4'h1; i++)
      cyc;
    tmo(i < 10);
    @(posedge sys_clk);
    ext_pin[1] <= 1'b0;
    for (i = 0; i < 10 && line !== 4'h0; i++)
      cyc;
    tmo(i < 10);
    $display("test external inputs done");
    wr(`PCC_OFS_PWRMODE, 32'h1);
    cyc;
    per(n);
    chk(32'(n), 32'h1);
    chk({30'h0, cpu_clk_en, mult_keep}, 32'h1);
    @(posedge sys_clk);
    periph_irq <= 1'b1;
    for (i = 0; i < 10 && cpu_clk_en !== 1'b1; i++)
      cyc;
    tmo(i < 10);
    @(posedge sys_clk);
    periph_irq <= 1'b0;
    cyc;
    chk({31'h0, irq}, 32'h1);
    wr(`PCC_OFS_INTSTAT, 32'h7);
    cyc;
    chk({31'h0, irq}, 32'h0);
    $display("test idle done");
    wr(`PCC_OFS_PWRMODE, 32'h2);
    repeat (8) cyc;
    chk({29'h0, osc_enable, pin_hold, cpu_clk_en}, 32'h2);
    chk({20'h0, pce}, 32'h0);
    @(posedge sys_clk);
    ext_pin[0] <= 1'b1;
    for (i = 0; i < 600 && cpu_clk_en !== 1'b1; i++)
      cyc;
    tmo(i < 600);
    chk(32'(i >= `PCC_WAKE_CYC), 32'h1);
    chk({31'h0, pin_hold}, 32'h0);
    rd(`PCC_OFS_INTSTAT, d);
    chk(d, 32'h2);
    rd(`PCC_OFS_PERIPHON, d);
    chk(d, 32'hA5A);
    chk({20'h0, pce}, 32'hA5A);
    chk({31'h0, vec_in_ram}, 32'h1);
    $display("test power-down done");
    // Both mode bits select power-down; only a reset brings it back here
    wr(`PCC_OFS_EXTWAKE, 32'h0);
    wr(`PCC_OFS_PWRMODE, 32'h3);
    cyc;
    chk({29'h0, osc_enable, pin_hold, cpu_clk_en}, 32'h2);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    cyc;
    chk({31'h0, cpu_clk_en}, 32'h1);
    chk({20'h0, pce}, 32'hFFF);
    chk({31'h0, vec_in_ram}, 32'h0);
    per(n);
    chk(32'(n), 32'h4);
    $display("test reset in power-down done");
    tally_and_finish;
  end
endmodule // pcc_top_tb
